// File: design/flash_ctrl_pkg.sv
// Package with register offsets, fields, commands and timing for the flash controller.
package flash_ctrl_pkg;
   // Register offsets on the peripheral register port.
   localparam logic [7:0] off_mode = 8'h00;
   localparam logic [7:0] off_command = 8'h04;
   localparam logic [7:0] off_status = 8'h08;
   localparam logic [7:0] off_result = 8'h0c;
   // Status field positions.
   localparam int bit_ready = 0;
   localparam int bit_bad_command = 1;
   localparam int bit_lock_violation = 2;
   localparam int bit_verify_failure = 3;
   localparam int bit_low_ecc = 16;
   // Mode register fields and reset value.
   localparam int bit_ready_int_en = 0;
   localparam int wait_state_lsb = 8;
   localparam logic [31:0] mode_reset = 32'h0000_0000;
   // Command word layout: key in the top byte, argument in the middle, opcode in the low byte.
   localparam logic [7:0] command_key = 8'h5a;
   typedef enum logic [7:0] {
      cmd_get_descriptor = 8'h00,
      cmd_write_page = 8'h01,
      cmd_write_page_lock = 8'h02,
      cmd_erase_write_page = 8'h03,
      cmd_erase_write_page_lock = 8'h04,
      cmd_erase_all = 8'h05,
      cmd_erase_pages = 8'h07,
      cmd_set_lock = 8'h08,
      cmd_clear_lock = 8'h09,
      cmd_erase_block = 8'h0a,
      cmd_erase_sector = 8'h0b,
      cmd_write_signature = 8'h12,
      cmd_erase_signature = 8'h13
   } command_t;
   // Erase granularity in bytes.
   localparam int page_bytes = 512;
   localparam int block_bytes = 8192;
   localparam int sector_bytes = 131072;
   // Size of the small sector region at the bottom of the array, in bytes.
   localparam int small_region_bytes = 16384;
   // Descriptor words; the descriptor command returns only descriptor_size.
   localparam logic [31:0] descriptor_size = 32'h0020_0000;
   localparam logic [31:0] descriptor_page = 32'h0000_0200;
   // Operation time per array step in ns, and its cycle count at 50 ns.
   localparam int step_time_ns = 400;
   localparam int clk_period_ns = 50;
   localparam int step_cycles = (step_time_ns + clk_period_ns - 1) / clk_period_ns;
endpackage : flash_ctrl_pkg

// File: design/flash_op_timer.sv
// Step timer that paces the flash array operation.
`timescale 1ns/10ps
module flash_op_timer #(
   parameter int cycles = flash_ctrl_pkg::step_cycles
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic start,
   output logic done
);
   logic [15:0] count;
   logic [15:0] next_count;
   logic running;
   logic next_running;

   // Counts down once started; done pulses on the last count.
   always_comb begin
      next_count = count;
      next_running = running;
      done = 1'b0;
      if (start) begin
         next_count = 16'(cycles - 1);
         next_running = 1'b1;
      end else if (running) begin
         if (count == 16'h0000) begin
            next_running = 1'b0;
            done = 1'b1;
         end else begin
            next_count = count - 16'h0001;
         end
      end
   end

   // Registers only.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         count <= 16'h0000;
         running <= 1'b0;
      end else begin
         count <= next_count;
         running <= next_running;
      end
   end
endmodule // flash_op_timer

// File: design/flash_controller_status.sv
// Flash controller: command sequencer, status flags and descriptor reply.
//
// Overview of operation
// - Erase one 8-kilobyte block on command.
// - Erase one 128-kilobyte sector on command.
// - Page erase allowed only in small sectors.
// - Erase-write page commands only in small sectors.
// - Signature page separate; erase pin spares it.
// - Masters read array and fill write buffer.
// - Sequence program, erase, lock, unlock commands.
// - Descriptor command reports flash organisation.
// - Bit 16 single ECC flag, clear on read.
// - Bit 3 verify failure, cleared when a command starts an array operation.
// - Bit 2 lock violation, clear read/command.
// - Bit 1 bad command, clear read/command.
// - Bit 0 ready, zero while busy.
// - Ready with enable raises interrupt request.
`timescale 1ns/10ps
module flash_controller_status #(
   parameter int addr_width = 21,
   parameter int region_count = 16
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic reg_sel,
   input wire logic reg_write,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   input wire logic bus_read,
   input wire logic bus_write,
   input wire logic [addr_width-1:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   output logic [31:0] bus_rdata,
   output logic [31:0] array_addr,
   output logic array_read,
   input wire logic [31:0] array_rdata,
   input wire logic array_single_ecc,
   output logic buffer_write,
   output logic [31:0] buffer_data,
   output logic [3:0] array_op,
   output logic array_op_start,
   output logic array_signature,
   input wire logic array_verify_fail,
   input wire logic erase_pin,
   output logic [3:0] read_wait_states,
   output logic flash_irq
);
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_run = 2'b01,
      st_done = 2'b10
   } state_t;

   state_t state;
   state_t next_state;
   logic [31:0] mode;
   logic [31:0] next_mode;
   logic bad_command;
   logic next_bad_command;
   logic lock_violation;
   logic next_lock_violation;
   logic verify_failure;
   logic next_verify_failure;
   logic low_ecc;
   logic next_low_ecc;
   logic [region_count-1:0] lock_bits;
   logic [region_count-1:0] next_lock_bits;
   logic [31:0] result;
   logic [31:0] next_result;
   logic [3:0] op;
   logic [3:0] next_op;
   logic [15:0] arg;
   logic [15:0] next_arg;
   logic sig;
   logic next_sig;
   logic erase_meta;
   logic erase_sync;
   logic ecc_meta;
   logic ecc_sync;
   logic timer_start;
   logic timer_done;
   logic status_read;
   logic command_write;
   logic ready;
   logic [31:0] status_word;
   flash_ctrl_pkg::command_t cmd;

   // True when a page-argument lies inside the small sector region.
   function automatic logic in_small_region(input logic [15:0] page);
      in_small_region = (32'(page) * flash_ctrl_pkg::page_bytes)
         < flash_ctrl_pkg::small_region_bytes;
   endfunction

   // Lock region index of a page argument.
   function automatic int region_of(input logic [15:0] page);
      region_of = (32'(page) * flash_ctrl_pkg::page_bytes / flash_ctrl_pkg::sector_bytes)
         % region_count;
   endfunction

   flash_op_timer #(
      .cycles(flash_ctrl_pkg::step_cycles)
   ) u_timer (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .start(timer_start),
      .done(timer_done)
   );

   assign ready = (state == st_idle);
   assign status_read = reg_sel && !reg_write && reg_addr == flash_ctrl_pkg::off_status;
   assign command_write = reg_sel && reg_write && reg_addr == flash_ctrl_pkg::off_command;
   assign cmd = flash_ctrl_pkg::command_t'(reg_wdata[7:0]);
   assign flash_irq = ready && mode[flash_ctrl_pkg::bit_ready_int_en];
   assign read_wait_states = mode[flash_ctrl_pkg::wait_state_lsb +: 4];
   assign array_op = op;
   assign array_signature = sig;

   // Status word assembly; reserved bits read zero.
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[flash_ctrl_pkg::bit_ready] = ready;
      status_word[flash_ctrl_pkg::bit_bad_command] = bad_command;
      status_word[flash_ctrl_pkg::bit_lock_violation] = lock_violation;
      status_word[flash_ctrl_pkg::bit_verify_failure] = verify_failure;
      status_word[flash_ctrl_pkg::bit_low_ecc] = low_ecc;
   end

   // Master accesses pass to the array and the write buffer. follows.
   always_comb begin
      array_read = bus_read;
      buffer_write = bus_write;
      array_addr = 32'(bus_addr);
      bus_rdata = array_rdata;
      buffer_data = bus_wdata;
   end

   // Command decode, sequencing and flags. Sets win over clears in the same cycle.
   always_comb begin
      next_state = state;
      next_mode = mode;
      next_bad_command = bad_command;
      next_lock_violation = lock_violation;
      next_verify_failure = verify_failure;
      next_low_ecc = low_ecc;
      next_lock_bits = lock_bits;
      next_result = result;
      next_op = op;
      next_arg = arg;
      next_sig = sig;
      timer_start = 1'b0;
      array_op_start = 1'b0;
      if (status_read || command_write) begin
         next_bad_command = 1'b0;
         next_lock_violation = 1'b0;
      end
      if (status_read) begin
         next_low_ecc = 1'b0;
      end
      if (ecc_sync) begin
         next_low_ecc = 1'b1;
      end
      if (reg_sel && reg_write && reg_addr == flash_ctrl_pkg::off_mode) begin
         next_mode = reg_wdata;
      end
      case (state)
         st_idle: begin
            if (erase_sync) begin
               // The pin clears the main array and the locks, never the signature page.
               next_op = 4'(flash_ctrl_pkg::cmd_erase_all);
               next_sig = 1'b0;
               next_lock_bits = '0;
               array_op_start = 1'b1;
               timer_start = 1'b1;
               next_state = st_run;
            end else if (command_write) begin
               next_arg = reg_wdata[23:8];
               next_op = reg_wdata[3:0];
               next_sig = 1'b0;
               if (reg_wdata[31:24] != flash_ctrl_pkg::command_key) begin
                  next_bad_command = 1'b1;
               end else begin
                  case (cmd)
                     flash_ctrl_pkg::cmd_get_descriptor: begin
                        next_result = flash_ctrl_pkg::descriptor_size;
                        next_state = st_done;
                     end
                     flash_ctrl_pkg::cmd_erase_write_page,
                     flash_ctrl_pkg::cmd_erase_write_page_lock,
                     flash_ctrl_pkg::cmd_erase_pages: begin
                        if (!in_small_region(reg_wdata[23:8])) begin
                           next_bad_command = 1'b1;
                        end else if (lock_bits[region_of(reg_wdata[23:8])]) begin
                           next_lock_violation = 1'b1;
                        end else begin
                           next_verify_failure = 1'b0;
                           if (cmd == flash_ctrl_pkg::cmd_erase_write_page_lock) begin
                              next_lock_bits[region_of(reg_wdata[23:8])] = 1'b1;
                           end
                           array_op_start = 1'b1;
                           timer_start = 1'b1;
                           next_state = st_run;
                        end
                     end
                     flash_ctrl_pkg::cmd_write_page,
                     flash_ctrl_pkg::cmd_write_page_lock,
                     flash_ctrl_pkg::cmd_erase_block,
                     flash_ctrl_pkg::cmd_erase_sector: begin
                        // Block and sector erase act on 8 KB and 128 KB units.
                        if (lock_bits[region_of(reg_wdata[23:8])]) begin
                           next_lock_violation = 1'b1;
                        end else begin
                           next_verify_failure = 1'b0;
                           if (cmd == flash_ctrl_pkg::cmd_write_page_lock) begin
                              next_lock_bits[region_of(reg_wdata[23:8])] = 1'b1;
                           end
                           array_op_start = 1'b1;
                           timer_start = 1'b1;
                           next_state = st_run;
                        end
                     end
                     flash_ctrl_pkg::cmd_erase_all,
                     flash_ctrl_pkg::cmd_write_signature,
                     flash_ctrl_pkg::cmd_erase_signature: begin
                        next_verify_failure = 1'b0;
                        next_sig = (cmd != flash_ctrl_pkg::cmd_erase_all);
                        array_op_start = 1'b1;
                        timer_start = 1'b1;
                        next_state = st_run;
                     end
                     flash_ctrl_pkg::cmd_set_lock: begin
                        next_lock_bits[region_of(reg_wdata[23:8])] = 1'b1;
                        next_state = st_done;
                     end
                     flash_ctrl_pkg::cmd_clear_lock: begin
                        next_lock_bits[region_of(reg_wdata[23:8])] = 1'b0;
                        next_state = st_done;
                     end
                     default: next_bad_command = 1'b1;
                  endcase
               end
            end
         end
         st_run: begin
            // Commands written while busy are dropped; software must wait for ready.
            if (timer_done) begin
               if (array_verify_fail) begin
                  next_verify_failure = 1'b1;
               end
               next_state = st_done;
            end
         end
         st_done: next_state = st_idle;
         default: next_state = st_idle;
      endcase
   end

   // Flag, mode and sequencer registers.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= st_idle;
         mode <= flash_ctrl_pkg::mode_reset;
         bad_command <= 1'b0;
         lock_violation <= 1'b0;
         verify_failure <= 1'b0;
         low_ecc <= 1'b0;
         lock_bits <= '0;
         result <= 32'h0000_0000;
         op <= 4'h0;
         arg <= 16'h0000;
         sig <= 1'b0;
      end else begin
         state <= next_state;
         mode <= next_mode;
         bad_command <= next_bad_command;
         lock_violation <= next_lock_violation;
         verify_failure <= next_verify_failure;
         low_ecc <= next_low_ecc;
         lock_bits <= next_lock_bits;
         result <= next_result;
         op <= next_op;
         arg <= next_arg;
         sig <= next_sig;
      end
   end

   // Pin and array event synchronisers; first stage feeds only the second.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         erase_meta <= 1'b0;
         erase_sync <= 1'b0;
         ecc_meta <= 1'b0;
         ecc_sync <= 1'b0;
      end else begin
         erase_meta <= erase_pin;
         erase_sync <= erase_meta;
         ecc_meta <= array_single_ecc;
         ecc_sync <= ecc_meta;
      end
   end

   // Registered read data.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_sel && !reg_write) begin
         case (reg_addr)
            flash_ctrl_pkg::off_mode: reg_rdata <= mode;
            flash_ctrl_pkg::off_status: reg_rdata <= status_word;
            flash_ctrl_pkg::off_result: reg_rdata <= result;
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end
   end

   AST_READY_BUSY: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state == st_run |-> !status_word[0]) else $error("ready shown while busy");
   AST_IRQ: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ready && mode[0] |-> flash_irq) else $error("irq missing");
   AST_ECC_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ecc_sync |=> low_ecc) else $error("ecc flag not set");
   AST_ECC_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n)
      status_read && !ecc_sync |=> !low_ecc) else $error("ecc flag not cleared");
   AST_LOCK_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n)
      status_read |=> !lock_violation) else $error("lock flag kept");
   AST_CMD_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n)
      status_read |=> !bad_command) else $error("cmd flag kept");
   // The erase pin takes priority in idle and drops a command written in the same cycle.
   AST_BAD_KEY: assert property (@(posedge clk_sys) disable iff (!rst_n)
      command_write && ready && !erase_sync && reg_wdata[31:24] != flash_ctrl_pkg::command_key
      |=> bad_command) else $error("bad key not flagged");
   AST_VERIFY_START: assert property (@(posedge clk_sys) disable iff (!rst_n)
      array_op_start && !erase_sync |=> !verify_failure) else $error("verify kept");
   AST_PAGE_RANGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      command_write && ready && !erase_sync && cmd == flash_ctrl_pkg::cmd_erase_pages
      && !in_small_region(reg_wdata[23:8]) |-> !array_op_start)
      else $error("page erase outside small sectors");
   AST_RUN_ENDS: assert property (@(posedge clk_sys) disable iff (!rst_n)
      array_op_start |-> ##[1:20] state == st_done) else $error("operation hung");
   COV_RUN: cover property (@(posedge clk_sys) array_op_start);
   COV_FAIL: cover property (@(posedge clk_sys) verify_failure);
   COV_LOCK: cover property (@(posedge clk_sys) lock_violation);
endmodule // flash_controller_status

// File: verification/flash_array_model.sv
// Behavioural flash array facing the controller's array port.
`timescale 1ns/10ps
module flash_array_model (
   input wire logic clk_sys,
   input wire logic array_read,
   input wire logic [31:0] array_addr,
   input wire logic inject_fail,
   input wire logic inject_ecc,
   output logic [31:0] array_rdata,
   output logic array_single_ecc,
   output logic array_verify_fail
);
   logic [31:0] idle_data = 32'h0000_0000;

   // Released data turns over every cycle so that a stale word never passes for a fresh one.
   always @(posedge clk_sys) begin
      if (!array_read) idle_data <= ~idle_data;
   end

   // Read data is a fixed pattern of the address, so the bench can work it out on its own.
   always_comb begin
      array_rdata = array_read ? (array_addr ^ 32'ha5a5_a5a5) : idle_data;
      array_single_ecc = array_read & inject_ecc;
      array_verify_fail = inject_fail;
   end
endmodule // flash_array_model

// File: verification/testbench.sv
// Self-checking testbench for the flash controller command sequencer and status flags.
`timescale 1ns/10ps
module testbench;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic reg_sel = 1'b0;
   logic reg_write = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic bus_read = 1'b0;
   logic bus_write = 1'b0;
   logic [20:0] bus_addr = 21'h00_0000;
   logic [31:0] bus_wdata = 32'h0000_0000;
   logic erase_pin = 1'b0;
   logic inject_fail = 1'b0;
   logic inject_ecc = 1'b0;
   logic [31:0] reg_rdata, bus_rdata, array_addr, array_rdata, buffer_data;
   logic array_read, array_single_ecc, buffer_write, array_op_start, array_signature;
   logic array_verify_fail, flash_irq;
   logic [3:0] array_op, read_wait_states;
   int failures = 0;
   int checks_done = 0;
   int starts = 0;
   logic [31:0] rd;
   logic [63:0] rows [20];

   // System clock at 20 MHz.
   always #25 clk_sys = ~clk_sys;

   // Counts accepted operations, so a dropped or wrongly refused command shows as a missing start.
   always @(posedge clk_sys) begin
      if (array_op_start) starts <= starts + 1;
   end

   flash_controller_status dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_sel(reg_sel),
      .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .bus_read(bus_read), .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata), .array_addr(array_addr), .array_read(array_read),
      .array_rdata(array_rdata), .array_single_ecc(array_single_ecc),
      .buffer_write(buffer_write), .buffer_data(buffer_data), .array_op(array_op),
      .array_op_start(array_op_start), .array_signature(array_signature),
      .array_verify_fail(array_verify_fail), .erase_pin(erase_pin),
      .read_wait_states(read_wait_states), .flash_irq(flash_irq));

   flash_array_model far_side (.clk_sys(clk_sys), .array_read(array_read),
      .array_addr(array_addr), .inject_fail(inject_fail), .inject_ecc(inject_ecc),
      .array_rdata(array_rdata), .array_single_ecc(array_single_ecc),
      .array_verify_fail(array_verify_fail));

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_sel <= 1'b1;
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_sel <= 1'b0;
      reg_write <= 1'b0;
   endtask

   // Read data is registered at the taking edge, so it is picked up half a cycle later.
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_sel <= 1'b1;
      reg_write <= 1'b0;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_sel <= 1'b0;
      @(negedge clk_sys);
      d = reg_rdata;
   endtask

   // Waits out the longest operation instead of polling, since a status read clears flags.
   task automatic run_cmd(input logic [31:0] c);
      reg_wr(flash_ctrl_pkg::off_command, c);
      repeat (14) @(posedge clk_sys);
   endtask

   task automatic give_verdict;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // The whole sequence needs under 2000 cycles; 20000 cuts a hang short.
   initial begin
      #(20000 * 50);
      failures++;
      give_verdict();
   end

   // Main sequence: command table first, then flags, locks, mode and bus traffic.
   initial begin
      rows = '{{32'h5a00_0000, 32'h1}, {32'h5a00_0001, 32'h1}, {32'h5a00_0003, 32'h1},
         {32'h5a00_0005, 32'h1}, {32'h5a00_0007, 32'h1}, {32'h5a00_000a, 32'h1},
         {32'h5a00_000b, 32'h1}, {32'h5a00_0012, 32'h1}, {32'h5a00_0013, 32'h1},
         {32'h5a00_0008, 32'h1}, {32'h5a00_0009, 32'h1}, {32'h5a00_0002, 32'h1},
         {32'h5a00_0009, 32'h1}, {32'h5a00_0004, 32'h1}, {32'h5a00_0009, 32'h1},
         {32'ha500_0001, 32'h3}, {32'h5a00_0006, 32'h3}, {32'h5a00_4003, 32'h3},
         {32'h5a00_4004, 32'h3}, {32'h5a00_4007, 32'h3}};
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      reg_rd(flash_ctrl_pkg::off_status, rd);
      check("status after reset", 32'h0000_0001, rd);
      reg_rd(flash_ctrl_pkg::off_mode, rd);
      check("mode after reset", flash_ctrl_pkg::mode_reset, rd);
      check("irq after reset", 32'h0, {31'h0, flash_irq});
      foreach (rows[i]) begin
         run_cmd(rows[i][63:32]);
         reg_rd(flash_ctrl_pkg::off_status, rd);
         check("status after command", rows[i][31:0], rd);
         reg_rd(flash_ctrl_pkg::off_status, rd);
         check("status read again", 32'h0000_0001, rd);
      end
      // Eight plain operations plus the two lock variants start the array; the rest do not.
      check("operation starts", 32'h0000_000a, starts);
      run_cmd(32'h5a00_0000);
      reg_rd(flash_ctrl_pkg::off_result, rd);
      check("descriptor", flash_ctrl_pkg::descriptor_size, rd);
      // A locked write is refused; the next command write clears the flag.
      run_cmd(32'h5a00_0008);
      run_cmd(32'h5a00_0001);
      reg_rd(flash_ctrl_pkg::off_status, rd);
      check("lock violation", 32'h0000_0005, rd);
      run_cmd(32'h5a00_0001);
      run_cmd(32'h5a00_0000);
      reg_rd(flash_ctrl_pkg::off_status, rd);
      check("lock flag after command", 32'h0000_0001, rd);
      run_cmd(32'h5a00_0012);
      check("signature selected", 32'h1, {31'h0, array_signature});
      check("signature opcode", 32'(4'(flash_ctrl_pkg::cmd_write_signature)), {28'h0, array_op});
      @(posedge clk_sys);
      erase_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      erase_pin <= 1'b0;
      // The pin's erase runs about ten cycles; a command before its end would be dropped.
      repeat (14) @(posedge clk_sys);
      check("erase pin spares signature", 32'h0, {31'h0, array_signature});
      check("erase pin opcode", 32'(4'(flash_ctrl_pkg::cmd_erase_all)), {28'h0, array_op});
      run_cmd(32'h5a00_0001);
      reg_rd(flash_ctrl_pkg::off_status, rd);
      check("write after erase pin", 32'h0000_0001, rd);
      // Verify failure is sticky across reads and cleared when the next command operation starts.
      @(posedge clk_sys);
      inject_fail <= 1'b1;
      run_cmd(32'h5a00_0001);
      reg_rd(flash_ctrl_pkg::off_status, rd);
      check("verify failure", 32'h0000_0009, rd);
      reg_rd(flash_ctrl_pkg::off_status, rd);
      check("verify failure kept", 32'h0000_0009, rd);
      @(posedge clk_sys);
      inject_fail <= 1'b0;
      reg_wr(flash_ctrl_pkg::off_mode, 32'h0000_0301);
      @(negedge clk_sys);
      check("wait states", 32'h3, {28'h0, read_wait_states});
      check("irq when ready", 32'h1, {31'h0, flash_irq});
      reg_wr(flash_ctrl_pkg::off_command, 32'h5a00_0001);
      @(negedge clk_sys);
      check("irq while busy", 32'h0, {31'h0, flash_irq});
      reg_rd(flash_ctrl_pkg::off_status, rd);
      check("status while busy", 32'h0000_0000, rd);
      repeat (14) @(posedge clk_sys);
      reg_rd(flash_ctrl_pkg::off_status, rd);
      check("status after clean write", 32'h0000_0001, rd);
      check("irq after operation", 32'h1, {31'h0, flash_irq});
      // Master read with a corrected error, then a write into the buffer.
      @(posedge clk_sys);
      bus_read <= 1'b1;
      bus_addr <= 21'h01_2344;
      inject_ecc <= 1'b1;
      @(negedge clk_sys);
      check("array read", 32'h1, {31'h0, array_read});
      check("array address", 32'h0001_2344, array_addr);
      check("bus read data", 32'h0001_2344 ^ 32'ha5a5_a5a5, bus_rdata);
      @(posedge clk_sys);
      bus_read <= 1'b0;
      inject_ecc <= 1'b0;
      bus_write <= 1'b1;
      bus_wdata <= 32'hc3c3_1234;
      @(negedge clk_sys);
      check("buffer write", 32'h1, {31'h0, buffer_write});
      check("buffer data", 32'hc3c3_1234, buffer_data);
      @(posedge clk_sys);
      bus_write <= 1'b0;
      repeat (4) @(posedge clk_sys);
      reg_rd(flash_ctrl_pkg::off_status, rd);
      check("ecc flag", 32'h0001_0001, rd);
      reg_rd(flash_ctrl_pkg::off_status, rd);
      check("ecc flag after read", 32'h0000_0001, rd);
      // A second reset with the controller idle drops a pending bad command flag.
      run_cmd(32'ha500_0001);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      reg_rd(flash_ctrl_pkg::off_status, rd);
      check("status after second reset", 32'h0000_0001, rd);
      reg_rd(flash_ctrl_pkg::off_mode, rd);
      check("mode after second reset", flash_ctrl_pkg::mode_reset, rd);
      check("irq after second reset", 32'h0, {31'h0, flash_irq});
      give_verdict();
   end
endmodule // testbench
